// File: common/hprs_pkg.sv
package hprs_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_SHIFT = 8'h08;
  localparam logic [7:0] A_AFTER = 8'h0c;
  localparam logic [7:0] A_HDATA = 8'h10;
  localparam logic [7:0] A_POS = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_START = 0;
  localparam int CTRL_ABS = 1;
  localparam int CFG_METH_LSB = 0;
  localparam int CFG_DIR = 4;
  localparam int CFG_POL = 5;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_KNOWN = 2;
  localparam int STAT_MODE = 3;
  localparam int STAT_ST_LSB = 8;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // ****************************************
  // Homing methods
  // ****************************************
  localparam logic [3:0] M_DOG = 4'h0;
  localparam logic [3:0] M_COUNT = 4'h1;
  localparam logic [3:0] M_DATA = 4'h2;
  localparam logic [3:0] M_STOPPER = 4'h3;
  localparam logic [3:0] M_IGNORE = 4'h4;
  localparam logic [3:0] M_DOG_REAR = 4'h5;
  localparam logic [3:0] M_CNT_FRONT = 4'h6;
  localparam logic [3:0] M_CRADLE = 4'h7;
  localparam logic [3:0] M_DOG_Z1 = 4'h8;
  localparam logic [3:0] M_DOG_FRONT = 4'h9;
  localparam logic [3:0] M_DOGLESS = 4'ha;

  typedef enum logic [3:0] {
    ST_IDLE, ST_BACKOFF, ST_SEEK, ST_CREEP, ST_AFTER, ST_WAIT_Z,
    ST_REVERSE, ST_SHIFT, ST_STALL, ST_SET, ST_DONE
  } hprs_st_t;

  typedef struct packed {
    logic run;
    logic dir;
    logic creep;
  } hprs_mot_t;

  typedef struct packed {
    logic dog;
    logic zmark;
    logic step;
    logic step_dir;
    logic servo_on;
    logic stall;
    logic auto_manual_select;
    logic [7:0] pt_sel;
  } hprs_pin_t;

endpackage

// File: design/hprs_core.sv
`timescale 1ns/100ps
// Operation
// - Incremental system: home unknown after every reset, homing needed first.
// - Absolute system: restored position marks home known, no new homing.
// - Start on the dog: back off reverse until clear, then home.
// - Dog type: creep at front edge, first marker after rear edge, shift.
// - Count type: creep at front edge, after-dog distance, marker, shift.
// - Data setting: present position becomes home at once.
// - Stopper: home where the axis stalls against the stopper.
// - Ignore: position at servo-on becomes home.
// - Dog rear reference: after rear edge travel after-dog plus shift.
// - Count front reference: from front edge travel after-dog plus shift.
// - Dog cradle: home at first marker after front edge.
// - Dog first marker: reverse at front edge, first marker, shift.
// - Dog front reference: home exactly at the dog front edge.
// - Dogless: dog ignored, first marker then shift.
// - Direction 0 starts toward increasing addresses, 1 toward decreasing.
// - Polarity 0 detects dog when input off, 1 when on.
// - On completion current position loads the home position data, plus travel since servo-on for ignore.
module hprs_core
  import hprs_pkg::*;
#(
  parameter int PW = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hprs_pin_t pins,
  input wire logic abs_load,
  input wire logic [PW-1:0] abs_pos,
  output hprs_mot_t mot_cmd,
  output logic [PW-1:0] cur_pos,
  output logic home_done,
  output logic home_known
);

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  hprs_pin_t pin_s;
  logic dog_det_d_r;
  logic zmark_d_r;
  logic step_d_r;
  logic son_d_r;

  hprs_sync #(
    .W($bits(hprs_pin_t))
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(pins),
    .q(pin_s)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] cfg_r;
  logic abs_sys_r;
  logic [31:0] shift_r;
  logic [31:0] after_r;
  logic [PW-1:0] hdata_r;
  logic [31:0] prdata_r;

  wire [3:0] meth = cfg_r[CFG_METH_LSB +: 4];
  wire cfg_dir = cfg_r[CFG_DIR];
  wire cfg_pol = cfg_r[CFG_POL];
  wire dog_det = cfg_pol ? pin_s.dog : ~pin_s.dog;
  wire dog_rise = dog_det & ~dog_det_d_r;
  wire dog_fall = ~dog_det & dog_det_d_r;
  wire z_p = pin_s.zmark & ~zmark_d_r;
  wire step_p = pin_s.step & ~step_d_r;
  wire son_rise = pin_s.servo_on & ~son_d_r;

  // Dog history resets to the level idle pins give with reset polarity, so no false front edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dog_det_d_r <= 1'b1;
      zmark_d_r <= 1'b0;
      step_d_r <= 1'b0;
      son_d_r <= 1'b0;
    end else begin
      dog_det_d_r <= dog_det;
      zmark_d_r <= pin_s.zmark;
      step_d_r <= pin_s.step;
      son_d_r <= pin_s.servo_on;
    end
  end

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl = (paddr == A_CTRL);
  wire hit_cfg = (paddr == A_CFG);
  wire hit_shift = (paddr == A_SHIFT);
  wire hit_after = (paddr == A_AFTER);
  wire hit_hdata = (paddr == A_HDATA);
  wire hit_pos = (paddr == A_POS);
  wire hit_stat = (paddr == A_STAT);
  wire hit = hit_ctrl | hit_cfg | hit_shift | hit_after | hit_hdata | hit_pos | hit_stat;
  wire wr = access & pwrite;
  wire wr_ctrl = wr & hit_ctrl;

  hprs_st_t st_r;
  hprs_st_t st_nxt;
  logic [PW-1:0] pos_r;
  logic [PW-1:0] son_pos_r;
  logic known_r;
  logic done_r;
  logic dist_zero;

  wire busy = (st_r != ST_IDLE) && (st_r != ST_DONE);
  // manual homing mode selected by host
  wire mode_ok = pin_s.auto_manual_select & (pin_s.pt_sel == 8'h00);
  wire start_acc = wr_ctrl & pwdata[CTRL_START] & mode_ok & ~busy;

  wire [31:0] stat_w = {20'h00000, st_r, 4'h0, mode_ok, known_r, busy, done_r};
  wire [31:0] ctrl_w = {30'h00000000, abs_sys_r, 1'b0};
  wire [31:0] pos_w = 32'(pos_r);
  wire [31:0] hdata_w = 32'(hdata_r);
  wire [31:0] rd_mux = hit_ctrl ? ctrl_w :
                       hit_cfg ? cfg_r :
                       hit_shift ? shift_r :
                       hit_after ? after_r :
                       hit_hdata ? hdata_w :
                       hit_pos ? pos_w :
                       hit_stat ? stat_w : RST_WORD;

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= RST_WORD;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= RST_WORD;
      abs_sys_r <= 1'b0;
      shift_r <= RST_WORD;
      after_r <= RST_WORD;
      hdata_r <= '0;
    end else if (wr) begin
      if (hit_ctrl) abs_sys_r <= pwdata[CTRL_ABS];
      if (hit_cfg) cfg_r <= {26'h0000000, pwdata[5:0]};
      if (hit_shift) shift_r <= pwdata;
      if (hit_after) after_r <= pwdata;
      if (hit_hdata) hdata_r <= PW'(pwdata);
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // ****************************************
  // Homing sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE, ST_DONE: begin
        if (start_acc) begin
          case (meth)
            M_DATA: st_nxt = ST_SET;
            M_IGNORE: st_nxt = ST_SET;
            M_STOPPER: st_nxt = ST_STALL;
            M_DOGLESS: st_nxt = ST_WAIT_Z;
            default: st_nxt = dog_det ? ST_BACKOFF : ST_SEEK;
          endcase
        end
      end
      ST_BACKOFF: begin
        if (!dog_det) st_nxt = ST_SEEK;
      end
      ST_SEEK: begin
        if (dog_rise) begin
          case (meth)
            M_DOG, M_DOG_REAR: st_nxt = ST_CREEP;
            M_COUNT, M_CNT_FRONT: st_nxt = ST_AFTER;
            M_CRADLE: st_nxt = ST_WAIT_Z;
            M_DOG_Z1: st_nxt = ST_REVERSE;
            M_DOG_FRONT: st_nxt = ST_SET;
            default: st_nxt = ST_IDLE;
          endcase
        end
      end
      ST_CREEP: begin
        if (dog_fall) st_nxt = (meth == M_DOG_REAR) ? ST_AFTER : ST_WAIT_Z;
      end
      ST_AFTER: begin
        if (dist_zero) st_nxt = (meth == M_COUNT) ? ST_WAIT_Z : ST_SHIFT;
      end
      ST_WAIT_Z: begin
        if (z_p) st_nxt = (meth == M_CRADLE) ? ST_SET : ST_SHIFT;
      end
      ST_REVERSE: begin
        if (z_p) st_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (dist_zero) st_nxt = ST_SET;
      end
      ST_STALL: begin
        if (pin_s.stall) st_nxt = ST_SET;
      end
      ST_SET: st_nxt = ST_DONE;
      default: st_nxt = ST_IDLE;
    endcase
    // Leaving manual mode aborts, so a stray table select cannot keep the axis moving
    if (busy && !mode_ok) st_nxt = ST_IDLE;
  end

  // ****************************************
  // Distance counter and motion command
  // ****************************************
  wire dist_ld = ((st_nxt == ST_AFTER) && (st_r != ST_AFTER)) ||
                 ((st_nxt == ST_SHIFT) && (st_r != ST_SHIFT));
  wire [31:0] dist_val = (st_nxt == ST_AFTER) ? after_r : shift_r;

  hprs_dist #(
    .W(32)
  ) u_dist (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(dist_ld),
    .val(dist_val),
    .step(step_p),
    .zero(dist_zero)
  );

  wire run_nxt = (st_nxt != ST_IDLE) && (st_nxt != ST_SET) && (st_nxt != ST_DONE);
  wire rev_nxt = (st_nxt == ST_BACKOFF) || (st_nxt == ST_REVERSE) ||
                 ((st_nxt == ST_SHIFT) && (meth == M_DOG_Z1));
  wire dir_nxt = rev_nxt ? ~cfg_dir : cfg_dir;
  wire creep_nxt = run_nxt && (st_nxt != ST_SEEK) && (st_nxt != ST_BACKOFF);
  hprs_mot_t mot_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      mot_r <= '0;
    end else begin
      st_r <= st_nxt;
      mot_r <= '{run: run_nxt, dir: run_nxt & dir_nxt, creep: creep_nxt};
    end
  end

  // ****************************************
  // Position, home state, completion
  // ****************************************
  wire [PW-1:0] ign_pos = hdata_r + (pos_r - son_pos_r);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pos_r <= '0;
      son_pos_r <= '0;
    end else begin
      if (son_rise) son_pos_r <= pos_r;
      if (st_r == ST_SET) begin
        pos_r <= (meth == M_IGNORE) ? ign_pos : hdata_r;
      end else if (abs_load && abs_sys_r && !busy) begin
        pos_r <= abs_pos;
      end else if (step_p) begin
        pos_r <= pin_s.step_dir ? pos_r - PW'(1) : pos_r + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      known_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (st_r == ST_SET) begin
        done_r <= 1'b1;
        known_r <= 1'b1;
      end else if (start_acc) begin
        done_r <= 1'b0;
        known_r <= 1'b0;
      end else if (abs_load && abs_sys_r && !busy) begin
        known_r <= 1'b1;
      end
    end
  end

  assign mot_cmd = mot_r;
  assign cur_pos = pos_r;
  assign home_done = done_r;
  assign home_known = known_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_BACKOFF: assert property (start_acc && dog_det && meth == M_DOG |=> st_r == ST_BACKOFF && mot_cmd.dir != cfg_dir)
    else $error("no back-off on dog");
  AST_SEEK_DIR: assert property (st_r == ST_SEEK |-> mot_cmd.run && mot_cmd.dir == cfg_dir && !mot_cmd.creep)
    else $error("seek direction wrong");
  AST_POL: assert property ($rose(pin_s.dog) && st_r == ST_SEEK && meth == M_DOG && cfg_pol |=> st_r == ST_CREEP)
    else $error("dog polarity not honoured");
  AST_CREEP: assert property (st_r == ST_CREEP && dog_fall && meth == M_DOG |=> st_r == ST_WAIT_Z && mot_cmd.creep)
    else $error("rear edge not followed by marker wait");
  AST_DATA: assert property (start_acc && meth == M_DATA |=> st_r == ST_SET ##1 done_r && pos_r == $past(hdata_r, 2))
    else $error("data setting homing failed");
  AST_FRONT: assert property (st_r == ST_SEEK && dog_rise && meth == M_DOG_FRONT |=> st_r == ST_SET)
    else $error("front edge not home");
  AST_REV: assert property (st_r == ST_REVERSE |-> mot_cmd.dir != cfg_dir)
    else $error("no reverse travel");
  AST_DOGLESS: assert property (start_acc && meth == M_DOGLESS |=> st_r == ST_WAIT_Z)
    else $error("dogless homing used dog");
  AST_CRADLE: assert property (st_r == ST_WAIT_Z && z_p && meth == M_CRADLE |=> st_r == ST_SET ##1 done_r)
    else $error("cradle marker missed");
  AST_HOME_LOAD: assert property (st_r == ST_SET && meth != M_IGNORE |=> pos_r == $past(hdata_r) && known_r)
    else $error("home data not loaded");
  AST_DONE_CLR: assert property (start_acc && meth != M_DATA && meth != M_IGNORE |=> !done_r && !known_r)
    else $error("done not cleared at start");
  AST_STALL: assert property (st_r == ST_STALL && pin_s.stall && mode_ok |=> st_r == ST_SET)
    else $error("stall not taken as home");

  COV_DOG: cover property (st_r == ST_SHIFT && meth == M_DOG ##[1:200] st_r == ST_DONE);
  COV_BACK: cover property (st_r == ST_BACKOFF ##[1:200] st_r == ST_SEEK);
  COV_COUNT: cover property (st_r == ST_AFTER && meth == M_COUNT ##[1:200] st_r == ST_WAIT_Z);
  COV_IGN: cover property (st_r == ST_SET && meth == M_IGNORE);

endmodule // hprs_core

// File: design/hprs_dist.sv
`timescale 1ns/100ps
module hprs_dist #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] val,
  input wire logic step,
  output logic zero
);
  logic [W-1:0] cnt_r;

  // Load wins over a step in the same cycle; the count stops at zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= val;
    end else if (step && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign zero = (cnt_r == '0);
endmodule // hprs_dist

// File: design/hprs_sync.sv
`timescale 1ns/100ps
module hprs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate

  assign q = s2_r;
endmodule // hprs_sync

// File: test/hprs_axis_model.sv
`timescale 1ns/100ps
module hprs_axis_model
  import hprs_pkg::*;
#(
  parameter int DOG_LO = 30,
  parameter int DOG_HI = 45,
  parameter int Z_PITCH = 16,
  parameter int STOP_AT = 20,
  parameter int STEP_DIV = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire hprs_mot_t mot_cmd,
  input wire logic pol,
  input wire logic servo_on,
  input wire logic stopper_on,
  input wire logic mode_sel,
  input wire logic [7:0] table_sel,
  output hprs_pin_t pins
);
  // ****************************************
  // Axis, dog, marker and stopper
  // ****************************************
  // Position is placed by the bench between runs, so reset leaves it alone
  int ap = 0;
  int div;
  logic step_r;
  logic dir_r;
  wire det = (ap >= DOG_LO) && (ap <= DOG_HI);
  wire stall = stopper_on && (ap >= STOP_AT);
  wire blocked = stall && !mot_cmd.dir;
  wire zmark = (ap % Z_PITCH) == 0;
  wire go = mot_cmd.run && !blocked;
  assign pins = {pol ? det : !det, zmark, step_r, dir_r, servo_on, stall, mode_sel, table_sel};

  // Slow steps: the sequencer sees each edge through its synchroniser before the next step
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div <= 0;
      step_r <= 1'b0;
      dir_r <= 1'b0;
    end else begin
      step_r <= 1'b0;
      div <= (go && div < STEP_DIV - 1) ? div + 1 : 0;
      if (go && div == STEP_DIV - 1) begin
        step_r <= 1'b1;
        dir_r <= mot_cmd.dir;
        ap <= mot_cmd.dir ? ap - 1 : ap + 1;
      end
    end
  end
endmodule // hprs_axis_model

// File: test/hprs_core_tb_top.sv
`timescale 1ns/100ps
module hprs_core_tb_top
  import hprs_pkg::*;
;
  // ****************************************
  // Bench signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, abs_pos = 32'h0, cur_pos;
  logic pready, pslverr, home_done, home_known;
  logic abs_load = 1'b0, pol = 1'b0, servo_on = 1'b0, stopper_on = 1'b0, mode_sel = 1'b1;
  logic [7:0] table_sel = 8'h00;
  hprs_pin_t pins;
  hprs_mot_t mot_cmd;
  int failures = 0;
  int n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  hprs_core #(.PW(32)) u_hprs_core (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .abs_load(abs_load), .abs_pos(abs_pos), .mot_cmd(mot_cmd), .cur_pos(cur_pos),
    .home_done(home_done), .home_known(home_known));
  hprs_axis_model u_hprs_axis_model (.clk_sys(clk_sys), .rstn(rstn), .mot_cmd(mot_cmd), .pol(pol),
    .servo_on(servo_on), .stopper_on(stopper_on), .mode_sel(mode_sel), .table_sel(table_sel), .pins(pins));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
    chk({31'h0, e}, {31'h0, exp_err}, what);
  endtask

  // One homing run from a placed axis position; the dog spans 30..45 in the axis model
  task automatic home(input logic [3:0] m, input logic d, input logic p, input int start, input int exp_ap);
    int n;
    logic fd;
    fd = d ^ (start >= 30 && start <= 45);
    u_hprs_axis_model.ap <= start;
    pol <= p;
    wr(A_CFG, {26'h0, p, d, m});
    wr(A_HDATA, 32'h100 + m);
    wr(A_CTRL, 32'h1);
    chk({31'h0, home_done}, 32'h0, "done cleared at start");
    n = 0;
    while (home_done !== 1'b1) begin
      @(posedge clk_sys);
      if (n == 4 && mot_cmd.run === 1'b1) chk({31'h0, mot_cmd.dir}, {31'h0, fd}, "start direction");
      n++;
    end
    chk(cur_pos, 32'h100 + m, "position loaded at completion");
    chk(u_hprs_axis_model.ap, exp_ap, "axis rest position");
    rdchk(A_STAT, 32'h00000a0d, 1'b0, "status after homing");
    $display("homing test method %0d finished", m);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, home_known}, 32'h0, "home unknown after reset");
    rdchk(A_CFG, RST_WORD, 1'b0, "config reset value");
    rdchk(8'h1c, 32'h0, 1'b1, "unmapped read");
    servo_on <= 1'b1;
    wr(A_SHIFT, 32'h3);
    wr(A_AFTER, 32'h5);
    table_sel <= 8'h01;
    repeat (3) @(posedge clk_sys);
    wr(A_CTRL, 32'h1);
    rdchk(A_STAT, 32'h0, 1'b0, "start refused outside manual homing");
    $display("mode selection test finished");
    table_sel <= 8'h00;
    repeat (3) @(posedge clk_sys);
    home(M_DOG, 1'b0, 1'b1, 0, 51);
    home(M_DOG, 1'b0, 1'b0, 35, 51);
    home(M_DOG, 1'b1, 1'b1, 60, 13);
    home(M_COUNT, 1'b0, 1'b1, 0, 51);
    home(M_DATA, 1'b0, 1'b1, 7, 7);
    stopper_on <= 1'b1;
    home(M_STOPPER, 1'b0, 1'b1, 2, 20);
    stopper_on <= 1'b0;
    home(M_DOG_REAR, 1'b0, 1'b1, 0, 54);
    home(M_CNT_FRONT, 1'b0, 1'b1, 0, 38);
    home(M_CRADLE, 1'b0, 1'b1, 0, 32);
    home(M_DOG_Z1, 1'b0, 1'b1, 0, 13);
    home(M_DOG_FRONT, 1'b0, 1'b1, 0, 30);
    home(M_DOGLESS, 1'b0, 1'b1, 2, 19);
    servo_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    servo_on <= 1'b1;
    repeat (4) @(posedge clk_sys);
    home(M_IGNORE, 1'b0, 1'b1, 5, 5);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, home_known}, 32'h0, "home unknown after second reset");
    wr(A_CTRL, 32'h2);
    rdchk(A_CTRL, 32'h2, 1'b0, "absolute system bit");
    abs_pos <= 32'h55;
    abs_load <= 1'b1;
    @(posedge clk_sys);
    abs_load <= 1'b0;
    @(posedge clk_sys);
    chk(cur_pos, 32'h55, "restored position");
    chk({31'h0, home_known}, 32'h1, "home known after restore");
    $display("absolute restore test finished");
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // hprs_core_tb_top
